// ==== design/ccs_card_cmd_setup.sv ====
// The plain strobed port and the register addresses are this design's own decisions.
`timescale 1ns/100ps
//Contract
// - The transfer-kind field decodes 0 single, 1 multiple, 2 stream, 4 SDIO byte, 5 SDIO block.
// - Direction bit 0 means write to the card and 1 means read from it.
// - Action field 0 is no data, 1 starts data, 2 stops data, 3 is reserved.
// - The response must come within 5 card cycles, or 64 when the latency bit is set.
// - The command line is push-pull when the drive bit is 0 and open-drain when it is 1.
// - Special kind 0 is an ordinary command with no extra handling.
// - Special kind 1 first runs 74 card clock cycles of initialization.
// - Special kind 2 holds the command until the current data block has ended.
// - Special kind 3 sends the command that disables the card completion signal.
// - Special kinds 4 and 5 mark the interrupt-mode command and response.
// - A four-bit count limits the master-clock wait between two data blocks.
// - The wait limit is count times multiplier, code 6 giving 65536 and code 7 1048576.
module ccs_card_cmd_setup #(
  parameter int CARD_DIV = 2
) (
  // clock and reset
  input  wire logic        i_clock,
  input  wire logic        i_arst_n,
  // register port
  input  wire logic [3:0]  i_addr,
  input  wire logic [31:0] i_wdata,
  input  wire logic        i_wr,
  input  wire logic        i_rd,
  output logic      [31:0] o_rdata,
  // command serializer
  input  wire logic        i_ser_drive,
  input  wire logic        i_ser_bit,
  input  wire logic        i_cmd_done,
  input  wire logic        i_resp_start,
  output logic             o_cmd_start,
  output logic             o_card_clk_en,
  output logic             o_init_active,
  // command line pin
  output logic             o_cmd_out,
  output logic             o_cmd_oe,
  // data path
  input  wire logic        i_block_end,
  input  wire logic        i_data_done,
  output logic             o_data_start,
  output logic             o_data_stop,
  output logic             o_data_read,
  // command kind flags
  output logic             o_kind_single,
  output logic             o_kind_multi,
  output logic             o_kind_stream,
  output logic             o_kind_sdio_byte,
  output logic             o_kind_sdio_block,
  output logic             o_cmpl_disable,
  output logic             o_irq_mode_cmd,
  output logic             o_irq_mode_resp
);
  ccs_tmr_if tif ();

  ccs_pkg::ccs_state_e state_ff;
  ccs_pkg::ccs_state_e nxt_state;
  logic [31:0] cmd_ff;
  logic [6:0]  tmo_ff;
  logic [6:0]  cnt_ff;
  logic        dbusy_ff;
  logic        lerr_ff;
  logic        tmo_err_ff;
  logic        bad_ff;
  logic        start_ff;
  logic        stop_ff;

  wire        clk_en;
  wire        wr_cmd  = i_wr && (i_addr == ccs_pkg::CMD_OFS);
  wire        wr_tmo  = i_wr && (i_addr == ccs_pkg::TMO_OFS);
  wire        wr_stat = i_wr && (i_addr == ccs_pkg::STAT_OFS);
  wire        idle    = (state_ff == ccs_pkg::ST_IDLE);
  wire        go      = wr_cmd && idle;
  wire [2:0]  kind    = cmd_ff[ccs_pkg::KIND_LSB +: 3];
  wire [1:0]  act     = cmd_ff[ccs_pkg::ACT_LSB +: 2];
  wire [2:0]  spc     = cmd_ff[ccs_pkg::SPC_LSB +: 3];
  wire [2:0]  w_kind  = i_wdata[ccs_pkg::KIND_LSB +: 3];
  wire [2:0]  w_spc   = i_wdata[ccs_pkg::SPC_LSB +: 3];
  wire        od_mode = cmd_ff[ccs_pkg::DRV_BIT];
  wire [6:0]  lat_lim;
  wire        init_end;
  wire        resp_end;
  wire        lat_miss;
  wire        w_bad;
  wire [31:0] stat;

  ccs_clk_div #(
    .DIV      (CARD_DIV)
  ) u_div (
    .i_clock  (i_clock),
    .i_arst_n (i_arst_n),
    .o_en     (clk_en)
  );

  ccs_timeout_timer u_tmr (
    .i_clock  (i_clock),
    .i_arst_n (i_arst_n),
    .tif      (tif.tmr)
  );

  // field decodes straight from the command register
  assign o_kind_single     = (kind == ccs_pkg::K_SINGLE);
  assign o_kind_multi      = (kind == ccs_pkg::K_MULTI);
  assign o_kind_stream     = (kind == ccs_pkg::K_STREAM);
  assign o_kind_sdio_byte  = (kind == ccs_pkg::K_SBYTE);
  assign o_kind_sdio_block = (kind == ccs_pkg::K_SBLOCK);
  assign o_data_read       = cmd_ff[ccs_pkg::DIR_BIT];
  assign o_cmpl_disable    = (spc == ccs_pkg::S_CDIS);
  assign o_irq_mode_cmd    = (spc == ccs_pkg::S_ICMD);
  assign o_irq_mode_resp   = (spc == ccs_pkg::S_IRSP);
  // undefined kind and special encodings are flagged, not acted on; reserved action 3 is not flagged
  assign w_bad = (w_kind == 3'h3) || (w_kind > ccs_pkg::K_SBLOCK)
              || (w_spc > ccs_pkg::S_IRSP);

  // command line: open-drain only ever pulls low
  assign o_cmd_out = od_mode ? 1'b0 : i_ser_bit;
  assign o_cmd_oe  = od_mode ? (i_ser_drive && !i_ser_bit) : i_ser_drive;

  // sequencing strobes
  assign o_card_clk_en = clk_en;
  assign o_init_active = (state_ff == ccs_pkg::ST_INIT);
  assign o_cmd_start   = (state_ff == ccs_pkg::ST_SEND);
  assign o_data_start  = start_ff;
  assign o_data_stop   = stop_ff;
  assign lat_lim  = cmd_ff[ccs_pkg::LAT_BIT] ? ccs_pkg::LAT_LONG : ccs_pkg::LAT_SHORT;
  assign init_end = clk_en && (cnt_ff == ccs_pkg::INIT_CYC - 7'h1);
  assign lat_miss = clk_en && !i_resp_start && (cnt_ff == lat_lim - 7'h1);
  assign resp_end = (state_ff == ccs_pkg::ST_RESP) && (i_resp_start || lat_miss);

  // timer runs only while a data transfer is open
  assign tif.run    = dbusy_ff;
  assign tif.reload = i_block_end;
  assign tif.count  = tmo_ff[ccs_pkg::CNT_LSB +: 4];
  assign tif.mcode  = tmo_ff[ccs_pkg::MUL_LSB +: 3];

  // next state; a new command is refused while one is in flight
  always_comb begin
    nxt_state = state_ff;
    case (state_ff)
      ccs_pkg::ST_IDLE: begin
        if (go) begin
          if (w_spc == ccs_pkg::S_INIT) nxt_state = ccs_pkg::ST_INIT;
          else if (w_spc == ccs_pkg::S_SYNC && dbusy_ff) nxt_state = ccs_pkg::ST_SYNC;
          else nxt_state = ccs_pkg::ST_SEND;
        end
      end
      ccs_pkg::ST_INIT: begin
        if (init_end) nxt_state = ccs_pkg::ST_SEND;
      end
      ccs_pkg::ST_SYNC: begin
        if (i_block_end || !dbusy_ff) nxt_state = ccs_pkg::ST_SEND;
      end
      ccs_pkg::ST_SEND: begin
        if (i_cmd_done) nxt_state = ccs_pkg::ST_RESP;
      end
      ccs_pkg::ST_RESP: begin
        if (resp_end) nxt_state = ccs_pkg::ST_IDLE;
      end
      default: nxt_state = ccs_pkg::ST_IDLE;
    endcase
  end

  always_ff @(posedge i_clock or negedge i_arst_n) begin
    if (!i_arst_n) state_ff <= ccs_pkg::ST_IDLE;
    else state_ff <= nxt_state;
  end

  // card cycle counter for init length and response latency
  always_ff @(posedge i_clock or negedge i_arst_n) begin
    if (!i_arst_n) cnt_ff <= 7'h0;
    else if (state_ff != nxt_state) cnt_ff <= 7'h0;
    else if (clk_en) cnt_ff <= cnt_ff + 7'h1;
  end

  // registers written by software
  always_ff @(posedge i_clock or negedge i_arst_n) begin
    if (!i_arst_n) begin
      cmd_ff <= ccs_pkg::CMD_RST;
      tmo_ff <= ccs_pkg::TMO_RST[6:0];
      bad_ff <= 1'b0;
    end else begin
      if (go) cmd_ff <= i_wdata;
      if (wr_tmo) tmo_ff <= i_wdata[6:0];
      if (go && w_bad) bad_ff <= 1'b1;
      else if (wr_stat && i_wdata[ccs_pkg::ST_BAD]) bad_ff <= 1'b0;
    end
  end

  // data start and stop follow the response phase
  always_ff @(posedge i_clock or negedge i_arst_n) begin
    if (!i_arst_n) begin
      start_ff <= 1'b0;
      stop_ff  <= 1'b0;
    end else begin
      start_ff <= resp_end && (act == ccs_pkg::A_START);
      stop_ff  <= resp_end && (act == ccs_pkg::A_STOP);
    end
  end

  // open transfer; a timeout closes it as well as a stop or the last block
  always_ff @(posedge i_clock or negedge i_arst_n) begin
    if (!i_arst_n) dbusy_ff <= 1'b0;
    else if (start_ff) dbusy_ff <= 1'b1;
    else if (stop_ff || i_data_done || tif.expired) dbusy_ff <= 1'b0;
  end

  // sticky errors; a new event beats a clear in the same cycle
  always_ff @(posedge i_clock or negedge i_arst_n) begin
    if (!i_arst_n) begin
      lerr_ff    <= 1'b0;
      tmo_err_ff <= 1'b0;
    end else begin
      if (state_ff == ccs_pkg::ST_RESP && lat_miss) lerr_ff <= 1'b1;
      else if (wr_stat && i_wdata[ccs_pkg::ST_LERR]) lerr_ff <= 1'b0;
      if (tif.expired) tmo_err_ff <= 1'b1;
      else if (wr_stat && i_wdata[ccs_pkg::ST_TMO]) tmo_err_ff <= 1'b0;
    end
  end

  // status word and read mux; unmapped offsets read zero
  assign stat = {21'h0, state_ff, 3'h0, bad_ff, tmo_err_ff, lerr_ff, dbusy_ff, !idle};

  always_ff @(posedge i_clock or negedge i_arst_n) begin
    if (!i_arst_n) o_rdata <= 32'h0;
    else if (!i_rd) o_rdata <= 32'h0;
    else begin
      case (i_addr)
        ccs_pkg::CMD_OFS:  o_rdata <= cmd_ff;
        ccs_pkg::TMO_OFS:  o_rdata <= {25'h0, tmo_ff};
        ccs_pkg::STAT_OFS: o_rdata <= stat;
        default:           o_rdata <= 32'h0;
      endcase
    end
  end

  kind_decode_a: assert property (@(posedge i_clock) disable iff (!i_arst_n)
    o_kind_multi |-> !o_kind_single && !o_kind_stream && (cmd_ff[21:19] == 3'h1))
    else $error("multi block flag without kind 1");

  dir_follows_a: assert property (@(posedge i_clock) disable iff (!i_arst_n)
    go |=> (o_data_read == $past(i_wdata[18])))
    else $error("direction not taken from command write");

  data_start_a: assert property (@(posedge i_clock) disable iff (!i_arst_n)
    o_data_start |-> (act == 2'h1) && $past(state_ff == ccs_pkg::ST_RESP) ##1 dbusy_ff)
    else $error("data start without start action");

  no_act_quiet_a: assert property (@(posedge i_clock) disable iff (!i_arst_n)
    (o_data_start || o_data_stop) |-> (act != 2'h0) && (act != 2'h3))
    else $error("data strobe for no-data or reserved action");

  lat_bound_a: assert property (@(posedge i_clock) disable iff (!i_arst_n)
    (state_ff == ccs_pkg::ST_RESP) |-> (cnt_ff < lat_lim))
    else $error("response wait ran past its limit");

  lat_short_a: assert property (@(posedge i_clock) disable iff (!i_arst_n)
    (state_ff == ccs_pkg::ST_RESP && !cmd_ff[12] && lat_miss) |=> lerr_ff && idle)
    else $error("missed response not flagged");

  open_drain_a: assert property (@(posedge i_clock) disable iff (!i_arst_n)
    od_mode |-> !o_cmd_out && (o_cmd_oe == (i_ser_drive && !i_ser_bit)))
    else $error("open-drain line driven high");

  push_pull_a: assert property (@(posedge i_clock) disable iff (!i_arst_n)
    !od_mode |-> (o_cmd_oe == i_ser_drive) && (o_cmd_out == i_ser_bit))
    else $error("push-pull line does not follow serializer");

  init_len_a: assert property (@(posedge i_clock) disable iff (!i_arst_n)
    (o_init_active && nxt_state == ccs_pkg::ST_SEND) |-> clk_en && (cnt_ff == 7'h49))
    else $error("initialization not 74 card cycles");

  std_direct_a: assert property (@(posedge i_clock) disable iff (!i_arst_n)
    (go && w_spc == 3'h0) |=> o_cmd_start)
    else $error("ordinary command not sent at once");

  sync_hold_a: assert property (@(posedge i_clock) disable iff (!i_arst_n)
    (state_ff == ccs_pkg::ST_SYNC && !i_block_end && dbusy_ff) |=> !o_cmd_start)
    else $error("synchronized command sent before block end");

  flag_kind_a: assert property (@(posedge i_clock) disable iff (!i_arst_n)
    (o_irq_mode_cmd || o_irq_mode_resp || o_cmpl_disable) |-> (spc >= 3'h3) && (spc <= 3'h5))
    else $error("special flag for wrong kind");

  cover_init_c: cover property (@(posedge i_clock) disable iff (!i_arst_n)
    o_init_active ##1 o_cmd_start);
  cover_sync_c: cover property (@(posedge i_clock) disable iff (!i_arst_n)
    (state_ff == ccs_pkg::ST_SYNC) ##1 o_cmd_start);
  cover_lerr_c: cover property (@(posedge i_clock) disable iff (!i_arst_n)
    $rose(lerr_ff));
  cover_tmo_c: cover property (@(posedge i_clock) disable iff (!i_arst_n)
    $rose(tmo_err_ff));
  cover_stop_c: cover property (@(posedge i_clock) disable iff (!i_arst_n)
    o_data_stop ##1 !dbusy_ff);

  init_entry_a: assert property (@(posedge i_clock) disable iff (!i_arst_n)
    (go && w_spc == ccs_pkg::S_INIT) |=> o_init_active && !o_cmd_start)
    else $error("initialization phase not entered");

  sync_entry_a: assert property (@(posedge i_clock) disable iff (!i_arst_n)
    (go && w_spc == ccs_pkg::S_SYNC && dbusy_ff) |=> (state_ff == ccs_pkg::ST_SYNC))
    else $error("synchronized command not held back");

  data_stop_a: assert property (@(posedge i_clock) disable iff (!i_arst_n)
    o_data_stop |-> (act == ccs_pkg::A_STOP) ##1 !dbusy_ff)
    else $error("data stop did not close the transfer");
endmodule // ccs_card_cmd_setup

// ==== design/ccs_clk_div.sv ====
`timescale 1ns/100ps
module ccs_clk_div #(
  parameter int DIV = 2
) (
  // clock and reset
  input  wire logic i_clock,
  input  wire logic i_arst_n,
  // card clock enable
  output logic      o_en
);
  logic [15:0] cnt_ff;

  // the counter is 16 bits wide, so larger dividers cannot be served
  if (DIV < 1 || DIV > 65535) begin : g_bad_div
    $error("DIV out of range");
  end

  // one enable pulse every DIV master cycles
  assign o_en = (cnt_ff == 16'(DIV - 1));

  always_ff @(posedge i_clock or negedge i_arst_n) begin
    if (!i_arst_n) cnt_ff <= 16'h0;
    else cnt_ff <= o_en ? 16'h0 : cnt_ff + 16'h1;
  end
endmodule // ccs_clk_div

// ==== design/ccs_pkg.sv ====
package ccs_pkg;
  // register map, byte addresses on the register port
  localparam int          ADDR_W   = 4;
  localparam logic [3:0]  CMD_OFS  = 4'h0;
  localparam logic [3:0]  TMO_OFS  = 4'h4;
  localparam logic [3:0]  STAT_OFS = 4'h8;
  localparam logic [31:0] CMD_RST  = 32'h0;
  localparam logic [31:0] TMO_RST  = 32'h0;
  // command word fields
  localparam int KIND_LSB = 19;
  localparam int DIR_BIT  = 18;
  localparam int ACT_LSB  = 16;
  localparam int LAT_BIT  = 12;
  localparam int DRV_BIT  = 11;
  localparam int SPC_LSB  = 8;
  // timeout word fields
  localparam int CNT_LSB  = 0;
  localparam int MUL_LSB  = 4;
  // status word fields
  localparam int ST_BUSY  = 0;
  localparam int ST_DATA  = 1;
  localparam int ST_LERR  = 2;
  localparam int ST_TMO   = 3;
  localparam int ST_BAD   = 4;
  localparam int ST_FSM   = 8;
  // transfer kinds
  localparam logic [2:0] K_SINGLE = 3'h0;
  localparam logic [2:0] K_MULTI  = 3'h1;
  localparam logic [2:0] K_STREAM = 3'h2;
  localparam logic [2:0] K_SBYTE  = 3'h4;
  localparam logic [2:0] K_SBLOCK = 3'h5;
  // transfer actions
  localparam logic [1:0] A_NONE  = 2'h0;
  localparam logic [1:0] A_START = 2'h1;
  localparam logic [1:0] A_STOP  = 2'h2;
  // special command kinds
  localparam logic [2:0] S_STD  = 3'h0;
  localparam logic [2:0] S_INIT = 3'h1;
  localparam logic [2:0] S_SYNC = 3'h2;
  localparam logic [2:0] S_CDIS = 3'h3;
  localparam logic [2:0] S_ICMD = 3'h4;
  localparam logic [2:0] S_IRSP = 3'h5;
  // timing: latency and init length in card clock cycles, timeout multipliers in master cycles
  localparam logic [6:0] LAT_SHORT = 7'h05;
  localparam logic [6:0] LAT_LONG  = 7'h40;
  localparam logic [6:0] INIT_CYC  = 7'h4A;
  localparam logic [20:0] MUL_6 = 21'h010000;
  localparam logic [20:0] MUL_7 = 21'h100000;

  typedef enum logic [2:0] {
    ST_IDLE = 3'h0,
    ST_INIT = 3'h1,
    ST_SYNC = 3'h3,
    ST_SEND = 3'h2,
    ST_RESP = 3'h6
  } ccs_state_e;

  // timeout multiplier; codes below 6 give four to the power of the code
  function automatic logic [20:0] mult_of(input logic [2:0] code);
    case (code)
      3'h6:    mult_of = MUL_6;
      3'h7:    mult_of = MUL_7;
      default: mult_of = 21'h1 << {code, 1'b0};
    endcase
  endfunction
endpackage

// ==== design/ccs_timeout_timer.sv ====
`timescale 1ns/100ps
module ccs_timeout_timer (
  // clock and reset
  input  wire logic i_clock,
  input  wire logic i_arst_n,
  // control
  ccs_tmr_if.tmr    tif
);
  logic [20:0] mult;
  logic [24:0] prod;
  logic [23:0] limit;
  logic [23:0] cnt_ff;

  // limit is count times multiplier, fits 24 bits at its largest
  assign mult  = ccs_pkg::mult_of(tif.mcode);
  assign prod  = {21'h0, tif.count} * {4'h0, mult};
  assign limit = prod[23:0];
  // a zero count disables the wait limit
  assign tif.expired = tif.run && (limit != 24'h0) && (cnt_ff == limit - 24'h1);

  // master-clock cycles since the last block ended
  always_ff @(posedge i_clock or negedge i_arst_n) begin
    if (!i_arst_n) cnt_ff <= 24'h0;
    else if (!tif.run || tif.reload || tif.expired) cnt_ff <= 24'h0;
    else cnt_ff <= cnt_ff + 24'h1;
  end

  expire_at_limit_a: assert property (@(posedge i_clock) disable iff (!i_arst_n)
    tif.expired |-> (cnt_ff == limit - 24'h1) && tif.run)
    else $error("timer expired away from its limit");
endmodule // ccs_timeout_timer

// ==== design/ccs_tmr_if.sv ====
`timescale 1ns/100ps
// control of the inter-block completion timer
interface ccs_tmr_if;
  logic       run;
  logic       reload;
  logic [3:0] count;
  logic [2:0] mcode;
  logic       expired;
  modport ctrl (output run, reload, count, mcode, input expired);
  modport tmr  (input run, reload, count, mcode, output expired);
endinterface

// ==== dv/ccs_card_cmd_setup_tb_top.sv ====
`timescale 1ns/100ps
// self-checking bench for the command setup block
module ccs_card_cmd_setup_tb_top;
  localparam int D = 2;
  logic        clk, arst_n, wr, rd, blk_end, ser_drive, ser_bit, cmd_done, resp_start;
  logic        cmd_start, init_act, cmd_out, oe, d_start, d_stop, d_read;
  logic        c_dis, i_cmd, i_rsp, drv_md, tick, ddone;
  logic [3:0]  addr;
  wire  [4:0]  kinds;
  logic [7:0]  dly;
  logic [31:0] wdata, rdata, r, w;
  int          bad_count, num_checks, n, c;
  int          gap = 0;
  // only the defined transfer and special kinds are ever programmed
  int          kt[$] = {0, 1, 2, 4, 5};
  int          st[$] = {0, 3, 4, 5};

  ccs_card_cmd_setup #(.CARD_DIV(D)) ccs_card_cmd_setup_inst (
    .i_clock(clk), .i_arst_n(arst_n), .i_addr(addr), .i_wdata(wdata), .i_wr(wr), .i_rd(rd),
    .o_rdata(rdata), .i_ser_drive(ser_drive), .i_ser_bit(ser_bit), .i_cmd_done(cmd_done),
    .i_resp_start(resp_start), .o_cmd_start(cmd_start), .o_card_clk_en(tick),
    .o_init_active(init_act), .o_cmd_out(cmd_out), .o_cmd_oe(oe), .i_block_end(blk_end),
    .i_data_done(ddone), .o_data_start(d_start), .o_data_stop(d_stop), .o_data_read(d_read),
    .o_kind_single(kinds[4]), .o_kind_multi(kinds[3]), .o_kind_stream(kinds[2]),
    .o_kind_sdio_byte(kinds[1]), .o_kind_sdio_block(kinds[0]), .o_cmpl_disable(c_dis),
    .o_irq_mode_cmd(i_cmd), .o_irq_mode_resp(i_rsp));

  ccs_card_model ccs_card_model_inst (.i_clock(clk), .i_cmd_start(cmd_start),
    .i_resp_dly(dly), .o_ser_drive(ser_drive), .o_ser_bit(ser_bit), .o_cmd_done(cmd_done),
    .o_resp_start(resp_start));

  // free-running master clock
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  // one counted comparison; an unknown never passes
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    num_checks++;
    if (g !== e) begin
      bad_count++;
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic print_verdict;
    if (bad_count == 0 && num_checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask

  task automatic wr_reg(input logic [3:0] a, input logic [31:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask

  // read data stand only in the cycle after the strobe
  task automatic rd_reg(input logic [3:0] a, output logic [31:0] d);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1;
    d = rdata;
  endtask

  task automatic wait_hi(ref logic s, input int lim_c);
    for (int j = 0; j < lim_c; j++) begin
      @(posedge clk);
      #1;
      if (s === 1'b1) return;
    end
    bad_count++;
    print_verdict;
  endtask

  task automatic wait_idle;
    for (int j = 0; j < 400; j++) begin
      rd_reg(ccs_pkg::STAT_OFS, r);
      if (r[ccs_pkg::ST_BUSY] === 1'b0) return;
    end
    bad_count++;
    print_verdict;
  endtask

  function automatic logic [31:0] cmd_word(input int k, dr, a, l, dv, s);
    cmd_word = 32'((k << ccs_pkg::KIND_LSB) | (dr << ccs_pkg::DIR_BIT) | (a << ccs_pkg::ACT_LSB)
             | (l << ccs_pkg::LAT_BIT) | (dv << ccs_pkg::DRV_BIT) | (s << ccs_pkg::SPC_LSB));
  endfunction

  task automatic pulse_blk;
    @(posedge clk);
    blk_end <= 1'b1;
    @(posedge clk);
    blk_end <= 1'b0;
  endtask

  task automatic start_data;
    wr_reg(ccs_pkg::CMD_OFS, cmd_word(1, 1, 1, 0, 0, 0));
    wait_hi(d_start, 100);
    chk("data_start", 1, d_start);
  endtask

  // a block end restarts the wait; silence past count times multiplier closes the transfer
  task automatic run_tmo(input int code, input int cnt);
    int lim;
    lim = cnt * ((code == 6) ? 65536 : 4 ** code);
    wr_reg(ccs_pkg::TMO_OFS, 32'(code * 16 + cnt));
    rd_reg(ccs_pkg::TMO_OFS, r);
    chk("tmo_word", 32'(code * 16 + cnt), r);
    start_data;
    if (lim < 100) begin
      repeat (lim - 4) @(posedge clk);
      pulse_blk;
    end
    repeat (lim - 10) @(posedge clk);
    rd_reg(ccs_pkg::STAT_OFS, r);
    chk("open_no_tmo", 32'h2, r & 32'hA);
    repeat (20) @(posedge clk);
    rd_reg(ccs_pkg::STAT_OFS, r);
    chk("closed_tmo", 32'h8, r & 32'hA);
    wr_reg(ccs_pkg::STAT_OFS, 32'h1C);
  endtask

  // command pin follows the serializer; open-drain only ever pulls low;
  // card ticks keep their period, since latency and init length are counted in them
  always @(negedge clk) begin
    if (arst_n === 1'b1) begin
      chk("cmd_oe", drv_md ? (ser_drive & ~ser_bit) : ser_drive, oe);
      if (oe === 1'b1) chk("cmd_out", drv_md ? 1'b0 : ser_bit, cmd_out);
      if (tick === 1'b1) begin
        if (gap > 0) chk("tick_gap", D, gap);
        gap = 1;
      end else if (gap > 0) begin
        gap++;
      end
    end
  end

  // main sequence
  initial begin
    arst_n = 1'b0;
    wr = 1'b0;
    rd = 1'b0;
    blk_end = 1'b0;
    ddone = 1'b0;
    addr = 4'h0;
    wdata = 32'h0;
    dly = 8'h02;
    drv_md = 1'b0;
    bad_count = 0;
    num_checks = 0;
    void'($urandom(32'hA2BF56BB));
    repeat (4) @(posedge clk);
    arst_n <= 1'b1;
    rd_reg(ccs_pkg::CMD_OFS, r);
    chk("cmd_reset", ccs_pkg::CMD_RST, r);
    chk("kind_reset", 5'h10, kinds);
    rd_reg(ccs_pkg::TMO_OFS, r);
    chk("tmo_reset", ccs_pkg::TMO_RST, r);
    rd_reg(4'hC, r);
    chk("unmapped", 32'h0, r);
    // every legal kind, special kinds 0, 3, 4 and 5, both drive styles; a write while busy is dropped
    for (int i = 0; i < 5; i++) begin
      w = cmd_word(kt[i], $urandom % 2, 0, 0, i % 2, st[i % 4]);
      wr_reg(ccs_pkg::CMD_OFS, w);
      drv_md = w[ccs_pkg::DRV_BIT];
      wr_reg(ccs_pkg::CMD_OFS, w ^ 32'h00040000);
      rd_reg(ccs_pkg::CMD_OFS, r);
      chk("cmd_word", w, r);
      chk("kinds", {kt[i] == 0, kt[i] == 1, kt[i] == 2, kt[i] == 4, kt[i] == 5}, kinds);
      chk("dir_read", w[ccs_pkg::DIR_BIT], d_read);
      n = st[i % 4];
      chk("spc", {n == 3, n == 4, n == 5}, {c_dis, i_cmd, i_rsp});
      wait_idle;
      chk("lat_err_std", 0, r[ccs_pkg::ST_LERR]);
    end
    // a late answer breaks only the short limit; silence breaks the long one too
    for (int l = 0; l < 3; l++) begin
      dly = (l == 2) ? 8'hFF : 8'h14;
      wr_reg(ccs_pkg::CMD_OFS, cmd_word(0, 0, 0, l != 0, 0, 0));
      wait_idle;
      repeat (30) @(posedge clk);
      rd_reg(ccs_pkg::STAT_OFS, r);
      chk("lat_err", l != 1, r[ccs_pkg::ST_LERR]);
      wr_reg(ccs_pkg::STAT_OFS, 32'h1C);
    end
    dly = 8'h02;
    // initialization phase length in card ticks, then the command goes out
    wr_reg(ccs_pkg::CMD_OFS, cmd_word(0, 0, 0, 0, 0, 1));
    // the first init cycle follows the accepting edge at once, so sample it too
    n = 0;
    #1;
    for (int j = 0; j < 400 && (n == 0 || init_act === 1'b1); j++) begin
      if (init_act === 1'b1) n++;
      @(posedge clk);
      #1;
    end
    chk("init_len", 1, n >= 74 * D - D + 1 && n <= 74 * D + D - 1);
    wait_hi(cmd_start, 4);
    chk("init_then_cmd", 1, cmd_start);
    wait_idle;
    c = $urandom_range(2, 1);
    run_tmo(c, 3);
    run_tmo(6, 1);
    wr_reg(ccs_pkg::TMO_OFS, 32'h71);
    rd_reg(ccs_pkg::TMO_OFS, r);
    chk("tmo_code7", 32'h71, r);
    // synchronized command waits for the block end; a stop command then closes the data
    wr_reg(ccs_pkg::TMO_OFS, 32'h0);
    start_data;
    wr_reg(ccs_pkg::CMD_OFS, cmd_word(1, 1, 0, 0, 0, 2));
    repeat (6) @(posedge clk);
    #1;
    chk("sync_hold", 0, cmd_start);
    rd_reg(ccs_pkg::STAT_OFS, r);
    chk("sync_state", 32'(ccs_pkg::ST_SYNC), 32'(r[ccs_pkg::ST_FSM +: 3]));
    pulse_blk;
    wait_hi(cmd_start, 4);
    chk("sync_send", 1, cmd_start);
    wait_idle;
    wr_reg(ccs_pkg::CMD_OFS, cmd_word(1, 1, 2, 0, 0, 0));
    wait_hi(d_stop, 100);
    chk("data_stop", 1, d_stop);
    repeat (2) @(posedge clk);
    rd_reg(ccs_pkg::STAT_OFS, r);
    chk("data_closed", 0, r[ccs_pkg::ST_DATA]);
    // the data path reporting the last block closes the transfer as well
    start_data;
    rd_reg(ccs_pkg::STAT_OFS, r);
    chk("data_open", 1, r[ccs_pkg::ST_DATA]);
    @(posedge clk);
    ddone <= 1'b1;
    @(posedge clk);
    ddone <= 1'b0;
    repeat (2) @(posedge clk);
    rd_reg(ccs_pkg::STAT_OFS, r);
    chk("data_done_closed", 0, r[ccs_pkg::ST_DATA]);
    print_verdict;
  end
endmodule // ccs_card_cmd_setup_tb_top

// ==== dv/ccs_card_model.sv ====
`timescale 1ns/100ps
// serializer and card stand-in; the bench picks how late the card answers
module ccs_card_model (
  // clock
  input  wire logic       i_clock,
  // from the block
  input  wire logic       i_cmd_start,
  // answer delay in master cycles, all ones keeps the card silent
  input  wire logic [7:0] i_resp_dly,
  // to the block
  output logic            o_ser_drive,
  output logic            o_ser_bit,
  output logic            o_cmd_done,
  output logic            o_resp_start
);
  int cnt;
  int rcnt;

  initial begin
    o_ser_drive = 1'b0;
    o_ser_bit = 1'b0;
    o_cmd_done = 1'b0;
    o_resp_start = 1'b0;
    cnt = 0;
    rcnt = -1;
  end

  // bit pattern flips every cycle so a stale level never looks right
  always @(posedge i_clock) begin
    o_cmd_done <= 1'b0;
    o_resp_start <= 1'b0;
    o_ser_bit <= ~o_ser_bit;
    o_ser_drive <= i_cmd_start && !o_cmd_done;
    if (i_cmd_start && !o_cmd_done) begin
      cnt <= cnt + 1;
      if (cnt == 6) begin
        o_cmd_done <= 1'b1;
        cnt <= 0;
        rcnt <= (i_resp_dly == 8'hFF) ? -1 : int'(i_resp_dly);
      end
    end
    if (rcnt == 0) o_resp_start <= 1'b1;
    if (rcnt >= 0) rcnt <= rcnt - 1;
  end
endmodule // ccs_card_model
